// [design/osd_debouncer.sv]
// octal switch debouncer with gated bus outputs and change alert
// assumes inputs synchronous to core_clk; undervoltage flag from a monitor
`timescale 1ns/10ps
module osd_debouncer #(
    parameter int unsigned SAMPLE_CYCLES = osd_pkg::SAMPLE_CYCLES,
    parameter int unsigned QUAL_SAMPLES  = osd_pkg::QUAL_SAMPLES
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         nrst,
    // switch side
    input  wire logic [7:0]   raw_contact_x,
    input  wire logic         undervolt,
    // host bus side
    input  wire logic         bus_enable_n,
    output osd_pkg::osd_bus_t filtered_level_x,
    output logic              state_toggle_alert_n
);
    import osd_pkg::*;

    localparam int DW = $clog2(SAMPLE_CYCLES + 1);
    localparam int QW = $clog2(QUAL_SAMPLES + 1);

    logic [DW-1:0] div_cnt;
    logic          tick;
    logic [7:0]    level;
    logic [7:0]    next_level;
    logic [QW-1:0] stable_run;

    // ************************************************************
    // decode helpers
    // ************************************************************
    // true when a channel's sample disagrees with its filtered level
    function automatic logic differs(input logic sample,
                                     input logic held);
        return sample != held;
    endfunction

    // true on the sampling tick that completes qualification
    function automatic logic qual_done(input logic          at_tick,
                                       input logic [QW-1:0] count);
        return at_tick && (count == QW'(QUAL_SAMPLES - 1));
    endfunction

    // ************************************************************
    // shared sampling tick
    // ************************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= '0;
            tick    <= 1'b0;
        end else if (div_cnt == DW'(SAMPLE_CYCLES - 1)) begin
            div_cnt <= '0;
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick    <= 1'b0;
        end
    end

    // ************************************************************
    // per-channel qualification
    // ************************************************************
    // independent channels
    for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
        logic [QW-1:0] qcnt;
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
                qcnt <= '0;
            end else if (!differs(raw_contact_x[i], level[i])
                         || undervolt) begin
                qcnt <= '0;
            end else if (tick) begin
                qcnt <= qcnt + 1'b1;
            end
        end
        always_comb begin
            next_level[i] = level[i];
            if (undervolt) begin
                next_level[i] = raw_contact_x[i];
            end else if (differs(raw_contact_x[i], level[i])
                         && qual_done(tick, qcnt)) begin
                next_level[i] = raw_contact_x[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            level <= LEVEL_RESET;
        end else begin
            level <= next_level;
        end
    end

    // ************************************************************
    // bus drive
    // ************************************************************
    // gated bus drive
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            filtered_level_x <= '{out: LEVEL_RESET, oe: 8'h00};
        end else begin
            filtered_level_x.out <= next_level;
            filtered_level_x.oe  <= {8{~bus_enable_n}};
        end
    end

    // ************************************************************
    // change alert
    // ************************************************************
    // alert set and acknowledge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_toggle_alert_n <= 1'b1;
        end else if (!bus_enable_n) begin
            state_toggle_alert_n <= 1'b1;
        end else if (next_level != level) begin
            state_toggle_alert_n <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    // independent run of differing ticks on channel 0, used by the checks
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stable_run <= '0;
        end else if (raw_contact_x[0] == level[0] || undervolt) begin
            stable_run <= '0;
        end else if (tick && stable_run != QW'(QUAL_SAMPLES)) begin
            stable_run <= stable_run + 1'b1;
        end
    end

    // host is reading: enable held low
    sequence s_ack;
        !bus_enable_n;
    endsequence

    // channel 0 meets its final qualifying tick
    sequence s_ch0_load;
        tick && !undervolt && raw_contact_x[0] != level[0]
            && stable_run == QW'(QUAL_SAMPLES - 1);
    endsequence

    // alert pending and not yet acknowledged
    sequence s_alert_wait;
        !state_toggle_alert_n && bus_enable_n;
    endsequence

    a_out_tracks_level: assert property (@(posedge core_clk) disable iff (!nrst)
        filtered_level_x.out == level)
        else $error("bus data differs from filtered level");
    a_hold_no_tick: assert property (@(posedge core_clk) disable iff (!nrst)
        !tick && !$past(undervolt) && !undervolt ##1 !undervolt
        |-> $stable(level))
        else $error("level changed without a sampling tick");
    a_mismatch_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        raw_contact_x[0] == level[0] |=> g_ch[0].qcnt == '0)
        else $error("counter not cleared on match");
    a_uv_bypass: assert property (@(posedge core_clk) disable iff (!nrst)
        undervolt |=> level == $past(raw_contact_x))
        else $error("undervoltage bypass failed");
    a_oe_follow: assert property (@(posedge core_clk) disable iff (!nrst)
        ##1 filtered_level_x.oe == {8{~$past(bus_enable_n)}})
        else $error("output enable wrong");
    a_alert_set: assert property (@(posedge core_clk) disable iff (!nrst)
        bus_enable_n && next_level != level |=> !state_toggle_alert_n)
        else $error("alert not raised on change");
    a_alert_sync: assert property (@(posedge core_clk) disable iff (!nrst)
        $fell(state_toggle_alert_n) |-> $changed(level))
        else $error("alert moved apart from level");
    a_alert_ack: assert property (@(posedge core_clk) disable iff (!nrst)
        !bus_enable_n |=> state_toggle_alert_n)
        else $error("alert not held high while enabled");
    a_qual_time: assert property (@(posedge core_clk) disable iff (!nrst)
        $changed(level) && !$past(undervolt)
        |-> $past(g_ch[0].qcnt) == QW'(QUAL_SAMPLES - 1)
            || $past(level[0]) == level[0])
        else $error("level changed before qualification");
    a_ch0_load: assert property (@(posedge core_clk) disable iff (!nrst)
        s_ch0_load |=> level[0] == $past(raw_contact_x[0]))
        else $error("qualified contact not loaded");
    a_ch0_early: assert property (@(posedge core_clk) disable iff (!nrst)
        !undervolt && stable_run != QW'(QUAL_SAMPLES - 1)
        |=> $stable(level[0]))
        else $error("channel 0 changed before full qualification");
    a_alert_stands: assert property (@(posedge core_clk) disable iff (!nrst)
        s_alert_wait |=> !state_toggle_alert_n)
        else $error("alert released without acknowledge");
    a_oe_drive: assert property (@(posedge core_clk) disable iff (!nrst)
        s_ack |=> filtered_level_x.oe == 8'hFF)
        else $error("bus not driven while enabled");
    a_oe_release: assert property (@(posedge core_clk) disable iff (!nrst)
        bus_enable_n |=> filtered_level_x.oe == 8'h00)
        else $error("bus still driven after release");
    a_tick_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
        tick |=> !tick)
        else $error("sampling tick longer than one cycle");

    // ************************************************************
    // per-channel checks
    // ************************************************************
    for (genvar k = 0; k < CHANNELS; k++) begin : g_chk
        a_ch_clear: assert property (@(posedge core_clk) disable iff (!nrst)
            raw_contact_x[k] == level[k] |=> g_ch[k].qcnt == '0)
            else $error("channel counter not cleared on agreement");
        a_ch_alone: assert property (@(posedge core_clk) disable iff (!nrst)
            !undervolt && raw_contact_x[k] == level[k]
            |=> $stable(level[k]))
            else $error("channel level moved without its own contact");
        a_ch_bound: assert property (@(posedge core_clk) disable iff (!nrst)
            g_ch[k].qcnt <= QW'(QUAL_SAMPLES))
            else $error("qualification counter ran past full count");
    end
endmodule // osd_debouncer

// [design/osd_pkg.sv]
// package for the octal switch debouncer: timing, widths and carriers
// assumes a single 25 MHz core clock and synchronous switch inputs
package osd_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CORE_CLK_HZ   = 25_000_000;
    localparam int unsigned QUAL_TIME_MS  = 40;
    // sampling tick period in microseconds
    localparam int unsigned SAMPLE_US     = 1000;
    localparam int unsigned SAMPLE_CYCLES =
        (CORE_CLK_HZ / 1_000_000) * SAMPLE_US;
    localparam int unsigned QUAL_SAMPLES  = (QUAL_TIME_MS * 1000) / SAMPLE_US;
    localparam int unsigned CHANNELS      = 8;
    localparam logic [7:0]  LEVEL_RESET   = 8'hFF;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } osd_bus_t;
endpackage : osd_pkg

// [bench/osd_host.sv]
// host model: gates the debouncer onto a data bus and reads it
// assumes oe marks the bits the debouncer drives
`timescale 1ns/10ps
module osd_host (
    // clock and bus
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic       core_clk,
    output logic            bus_enable_n
);
    logic [7:0] bus;
    logic [7:0] last = 8'h00;
    // released bits show a pattern that flips every cycle
    always_comb bus = (out & oe) | (~last & ~oe);
    always @(posedge core_clk) last <= bus;
    initial bus_enable_n = 1'b1;
    task automatic hold_low(input logic on);
        @(posedge core_clk) bus_enable_n <= ~on;
    endtask
    // sample the bus as it stands now
    task automatic peek(output logic [7:0] v);
        v = bus;
    endtask
    task automatic read(output logic [7:0] v);
        @(posedge core_clk) bus_enable_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        v = bus;
        @(posedge core_clk) bus_enable_n <= 1'b1;
    endtask
endmodule // osd_host

// [bench/osd_debouncer_tb.sv]
// testbench for the octal switch debouncer and its host bus
// assumes short sampling parameters so qualification takes few cycles
`timescale 1ns/10ps
module osd_debouncer_tb;
    import osd_pkg::*;
    localparam int TB_SAMPLE = 4;
    localparam int TB_QUAL   = 3;
    // edges after the 6th at which qualification may land
    localparam int QUAL_MIN_WAIT = (TB_QUAL - 1) * TB_SAMPLE + 1 - 6;
    localparam int QUAL_MAX_WAIT = TB_QUAL * TB_SAMPLE - 6;
    logic       core_clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] raw_contact_x = 8'hFF;
    logic       undervolt = 1'b0;
    logic       bus_enable_n;
    osd_bus_t   filtered_level_x;
    logic       state_toggle_alert_n;
    logic [7:0] v;
    int         failures = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    always #20 core_clk = ~core_clk;
    wire logic [8:0] alert_oe = {state_toggle_alert_n, filtered_level_x.oe};
    osd_debouncer #(.SAMPLE_CYCLES(TB_SAMPLE), .QUAL_SAMPLES(TB_QUAL))
        osd_debouncer_inst (.core_clk, .nrst, .raw_contact_x,
        .undervolt, .bus_enable_n, .filtered_level_x,
        .state_toggle_alert_n);
    osd_host osd_host_inst (.out(filtered_level_x.out),
        .oe(filtered_level_x.oe), .core_clk, .bus_enable_n);
    task automatic chk(string n, logic [8:0] e, logic [8:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            end_sim();
        end
    end
    task automatic t_qualify();
        int n;
        @(posedge core_clk) raw_contact_x <= 8'hFE;
        repeat (6) @(posedge core_clk);
        #1 chk("held", 9'h1FF, {state_toggle_alert_n, filtered_level_x.out});
        n = 0;
        while (filtered_level_x.out === 8'hFF && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("qual", 9'h0FE, {state_toggle_alert_n, filtered_level_x.out});
        chk("qual time", 9'h001,
            {8'h00, (n >= QUAL_MIN_WAIT && n <= QUAL_MAX_WAIT)});
        $display("qualify done");
    endtask
    task automatic t_bounce();
        repeat (4) begin
            @(posedge core_clk) raw_contact_x <= 8'hFC;
            repeat (6) @(posedge core_clk);
            raw_contact_x <= 8'hFE;
            repeat (5) @(posedge core_clk);
        end
        #1 chk("bounce", 9'h0FE, {state_toggle_alert_n, filtered_level_x.out});
        $display("bounce done");
    endtask
    task automatic t_read();
        osd_host_inst.read(v);
        #1 chk("read", 9'h1FE, {state_toggle_alert_n, v});
        repeat (2) @(posedge core_clk);
        #1 chk("float", 9'h000, {1'b0, filtered_level_x.oe});
        $display("read done");
    endtask
    task automatic t_undervolt();
        @(posedge core_clk) undervolt <= 1'b1;
        raw_contact_x <= 8'h5A;
        repeat (2) @(posedge core_clk);
        #1 chk("bypass", 9'h05A, {1'b0, filtered_level_x.out});
        $display("undervolt done");
    endtask
    task automatic t_always_on();
        int n;
        @(posedge core_clk) undervolt <= 1'b0;
        osd_host_inst.hold_low(1'b1);
        raw_contact_x <= 8'hA5;
        n = 0;
        while (filtered_level_x.out !== 8'hA5 && n < 20) begin
            @(posedge core_clk);
            #1 n++;
        end
        osd_host_inst.peek(v);
        chk("open bus", 9'h1A5, {state_toggle_alert_n, v});
        osd_host_inst.hold_low(1'b0);
        repeat (2) @(posedge core_clk);
        #1 chk("no late alert", 9'h100, alert_oe);
        $display("always on done");
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        #1 chk("rst", 9'h1FF, {state_toggle_alert_n, filtered_level_x.out});
        chk("rst oe", 9'h000, {1'b0, filtered_level_x.oe});
        @(posedge core_clk) nrst <= 1'b1;
        t_qualify();
        t_bounce();
        t_read();
        t_undervolt();
        t_always_on();
        end_sim();
    end
endmodule // osd_debouncer_tb
